// [src/pin_fn_decode.sv]
module pin_fn_decode
  import pinmux_pkg::*;
#(
  parameter int PIN = 0
)
(
  input wire logic [2:0] code,
  output fn_t fn
);

  // unlisted and reserved codes fall back to gpio in the table
  always_comb
  begin
    fn = FN_MAP[PIN][code];
  end

endmodule // pin_fn_decode

// [src/pin_sync.sv]
module pin_sync
  import pinmux_pkg::*;
#(
  parameter int W = 8
)
(
  input wire logic CLK,
  input wire logic RST_B,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  logic [W-1:0] meta_r;

  // first stage feeds only the second stage
  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      meta_r <= '0;
      sync_out <= '0;
    end
    else
    begin
      meta_r <= async_in;
      sync_out <= meta_r;
    end
  end

endmodule // pin_sync

// [src/pinmux_pkg.sv]
// How it works
// - ext field 23:16, second 15:8, top reserved
// - pin code is extension, second, low bits
// - code zero routes pin to gpio
// - register at 0x08 resets to zero
// - pin5 maps mosi, uart tx, pwm3, sda
// - pin3 maps cs, pwm1, pll, data high, scl
// - pin2 maps clk, pwm0, data low, spi0 mosi
// - pin1 maps mosi, pwm7, valid, debug, crystal
// - pin0 maps miso, pwm6, converter clock
package pinmux_pkg;

  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam int NPIN = 8;
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] FUNC_SEL_OFS = 8'h08;
  localparam logic [31:0] FUNC_SEL_RST = 32'h0000_0000;
  localparam int EXT_LSB = 16;
  localparam int SEC_LSB = 8;
  localparam int LOW_LSB = 0;
  // low select bits exist only for pins 0,1,2,3,5
  localparam logic [7:0] LOW_MASK = 8'h2f;

  typedef struct packed {
    logic [7:0] ext;
    logic [7:0] sec;
    logic [7:0] low;
  } sel_t;

  typedef struct packed {
    logic dout;
    logic oe;
  } pad_t;

  // ----------------------------------------
  // pin functions
  // ----------------------------------------
  typedef enum logic [4:0] {
    FN_GPIO,
    FN_SPI1_MOSI,
    FN_SPI1_MISO,
    FN_SPI1_CS,
    FN_SPI1_CLK,
    FN_SPI0_MOSI,
    FN_UART1_TX,
    FN_I2C0_SDA,
    FN_I2C0_SCL,
    FN_PWM_CHANNEL0_OUTPUT,
    FN_PWM_CHANNEL1_OUTPUT,
    FN_PWM_CHANNEL3_OUTPUT,
    FN_PWM_CHANNEL6_OUTPUT,
    FN_PWM_CHANNEL7_OUTPUT,
    FN_PLL_CLOCK_BY_EIGHT,
    FN_CONV_DATA_HIGH,
    FN_CONV_DATA_LOW,
    FN_CONV_VALID,
    FN_CONV_CLOCK,
    FN_LINK_LAYER_DEBUG_BUS7,
    FN_CRYSTAL_QUICKSTART_CLOCK
  } fn_t;

  localparam int FN_COUNT = 21;

  // indexed [pin][{ext,second,low}]
  localparam fn_t FN_MAP [NPIN][8] = '{
    '{FN_GPIO, FN_SPI1_MISO, FN_PWM_CHANNEL6_OUTPUT, FN_CONV_CLOCK,
      FN_GPIO, FN_GPIO, FN_GPIO, FN_GPIO},
    '{FN_GPIO, FN_SPI1_MOSI, FN_PWM_CHANNEL7_OUTPUT, FN_CONV_VALID,
      FN_LINK_LAYER_DEBUG_BUS7, FN_GPIO, FN_CRYSTAL_QUICKSTART_CLOCK,
      FN_GPIO},
    '{FN_GPIO, FN_SPI1_CLK, FN_PWM_CHANNEL0_OUTPUT, FN_GPIO,
      FN_CONV_DATA_LOW, FN_GPIO, FN_SPI0_MOSI, FN_GPIO},
    '{FN_GPIO, FN_SPI1_CS, FN_PWM_CHANNEL1_OUTPUT, FN_PLL_CLOCK_BY_EIGHT,
      FN_CONV_DATA_HIGH, FN_GPIO, FN_I2C0_SCL, FN_GPIO},
    '{FN_GPIO, FN_GPIO, FN_GPIO, FN_GPIO,
      FN_GPIO, FN_GPIO, FN_GPIO, FN_GPIO},
    '{FN_GPIO, FN_SPI1_MOSI, FN_UART1_TX, FN_PWM_CHANNEL3_OUTPUT,
      FN_GPIO, FN_GPIO, FN_I2C0_SDA, FN_GPIO},
    '{FN_GPIO, FN_GPIO, FN_GPIO, FN_GPIO,
      FN_GPIO, FN_GPIO, FN_GPIO, FN_GPIO},
    '{FN_GPIO, FN_GPIO, FN_GPIO, FN_GPIO,
      FN_GPIO, FN_GPIO, FN_GPIO, FN_GPIO}
  };

endpackage

// [src/port2_pin_function_select.sv]
// Implementation choice: the strobed register port.
module port2_pin_function_select
  import pinmux_pkg::*;
(
  input wire logic CLK,
  input wire logic RST_B,
  input wire logic [ADDR_W-1:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [31:0] RDATA,
  input wire logic [NPIN-1:0] GPIO_DO,
  input wire logic [NPIN-1:0] GPIO_OE,
  output logic [NPIN-1:0] GPIO_DI,
  input wire logic [FN_COUNT-1:0] PERIPH_DO,
  input wire logic [FN_COUNT-1:0] PERIPH_OE,
  output logic [FN_COUNT-1:0] PERIPH_DI,
  input wire logic [NPIN-1:0] PAD_DI,
  output logic [NPIN-1:0] PAD_DO,
  output logic [NPIN-1:0] PAD_OE
);

  // ----------------------------------------
  // select register
  // ----------------------------------------
  sel_t sel_r;
  sel_t sel_nxt;
  logic sel_hit;

  assign sel_hit = (ADDR == FUNC_SEL_OFS);

  always_comb
  begin
    sel_nxt = sel_r;
    if (WR && sel_hit)
    begin
      sel_nxt.ext = WDATA[EXT_LSB +: 8];
      sel_nxt.sec = WDATA[SEC_LSB +: 8];
      sel_nxt.low = WDATA[LOW_LSB +: 8] & LOW_MASK;
    end
  end

  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
      sel_r <= FUNC_SEL_RST[23:0];
    else
      sel_r <= sel_nxt;
  end

  // ----------------------------------------
  // read port
  // ----------------------------------------
  // data stand only in the cycle after the strobe; zero elsewhere so
  // a stale value is never mistaken for a fresh read
  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
      RDATA <= '0;
    else if (RD && sel_hit)
      RDATA <= {8'h00, sel_r};
    else
      RDATA <= '0;
  end

  // ----------------------------------------
  // pad input synchroniser
  // ----------------------------------------
  logic [NPIN-1:0] pad_in_s;

  pin_sync #(
    .W(NPIN)
  ) u_pad_sync (
    .CLK(CLK),
    .RST_B(RST_B),
    .async_in(PAD_DI),
    .sync_out(pad_in_s)
  );

  // ----------------------------------------
  // per pin decode and output mux
  // ----------------------------------------
  logic [2:0] code [NPIN];
  fn_t fn [NPIN];
  pad_t pad_nxt [NPIN];
  pad_t pad_r [NPIN];

  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi++)
    begin : g_pin
      assign code[gi] = {sel_r.ext[gi], sel_r.sec[gi], sel_r.low[gi]};

      pin_fn_decode #(
        .PIN(gi)
      ) u_dec (
        .code(code[gi]),
        .fn(fn[gi])
      );

      always_comb
      begin
        if (fn[gi] == FN_GPIO)
        begin
          pad_nxt[gi].dout = GPIO_DO[gi];
          pad_nxt[gi].oe = GPIO_OE[gi];
        end
        else
        begin
          pad_nxt[gi].dout = PERIPH_DO[fn[gi]];
          pad_nxt[gi].oe = PERIPH_OE[fn[gi]];
        end
      end

      // registered so a select change never glitches the pad
      always_ff @(posedge CLK or negedge RST_B)
      begin
        if (!RST_B)
        begin
          pad_r[gi] <= '0;
        end
        else
        begin
          pad_r[gi] <= pad_nxt[gi];
        end
      end

      assign PAD_DO[gi] = pad_r[gi].dout;
      assign PAD_OE[gi] = pad_r[gi].oe;
    end
  endgenerate

  // ----------------------------------------
  // input return path
  // ----------------------------------------
  // gpio always sees its pad; a peripheral sees the lowest pin that
  // selects it, since two pins may carry the same spi1 mosi signal
  logic [FN_COUNT-1:0] periph_di_nxt;
  logic [FN_COUNT-1:0] periph_taken;

  always_comb
  begin
    periph_di_nxt = '0;
    periph_taken = '0;
    for (int p = 0; p < NPIN; p++)
    begin
      if (fn[p] != FN_GPIO && !periph_taken[fn[p]])
      begin
        periph_di_nxt[fn[p]] = pad_in_s[p];
        periph_taken[fn[p]] = 1'b1;
      end
    end
  end

  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
      PERIPH_DI <= '0;
    else
      PERIPH_DI <= periph_di_nxt;
  end

  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
      GPIO_DI <= '0;
    else
      GPIO_DI <= pad_in_s;
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  logic first_r;

  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
      first_r <= 1'b1;
    else
      first_r <= 1'b0;
  end

  a_reset_all_gpio: assert property (
    @(posedge CLK) disable iff (!RST_B)
    first_r |-> (sel_r == '0) && (PAD_OE == '0))
    else $error("select register not clear after reset");

  a_write_fields: assert property (
    @(posedge CLK) disable iff (!RST_B)
    (WR && sel_hit) |=> (sel_r.ext == $past(WDATA[23:16]))
      && (sel_r.sec == $past(WDATA[15:8])))
    else $error("extension or second field not stored");

  a_read_reserved: assert property (
    @(posedge CLK) disable iff (!RST_B)
    RD |=> (RDATA[31:24] == 8'h00) && (RDATA[7:6] == 2'h0)
      && (RDATA[4] == 1'b0))
    else $error("reserved bits read non-zero");

  a_read_back: assert property (
    @(posedge CLK) disable iff (!RST_B)
    (WR && sel_hit) ##1 (RD && sel_hit) |=>
      RDATA[23:0] == ($past(WDATA[23:0], 2) & 24'hffff2f))
    else $error("readback differs from written value");

  generate
    for (gi = 0; gi < NPIN; gi++)
    begin : g_chk
      // the release edge still loads reset values, so start one later
      a_gpio_route: assert property (
        @(posedge CLK) disable iff (!RST_B)
        !first_r && (code[gi] == 3'h0) |=>
          (PAD_DO[gi] == $past(GPIO_DO[gi]))
          && (PAD_OE[gi] == $past(GPIO_OE[gi])))
        else $error("zero code does not route gpio");
    end
  endgenerate

  a_pin5_uart: assert property (
    @(posedge CLK) disable iff (!RST_B)
    (code[5] == 3'h2) |=> PAD_DO[5] == $past(PERIPH_DO[FN_UART1_TX]))
    else $error("pin 5 not driven by uart1 tx");

  a_pin5_reserved: assert property (
    @(posedge CLK) disable iff (!RST_B)
    (code[5] == 3'h5 || code[5] == 3'h7) |=>
      PAD_OE[5] == $past(GPIO_OE[5]))
    else $error("reserved pin 5 code left gpio");

  a_pin3_pll: assert property (
    @(posedge CLK) disable iff (!RST_B)
    (code[3] == 3'h3) |=>
      PAD_DO[3] == $past(PERIPH_DO[FN_PLL_CLOCK_BY_EIGHT]))
    else $error("pin 3 not driven by pll clock");

  a_pin2_spi0: assert property (
    @(posedge CLK) disable iff (!RST_B)
    (code[2] == 3'h6) |=> PAD_DO[2] == $past(PERIPH_DO[FN_SPI0_MOSI]))
    else $error("pin 2 not driven by spi0 mosi");

  a_pin1_crystal: assert property (
    @(posedge CLK) disable iff (!RST_B)
    (code[1] == 3'h6) |=>
      PAD_DO[1] == $past(PERIPH_DO[FN_CRYSTAL_QUICKSTART_CLOCK]))
    else $error("pin 1 not driven by crystal clock");

  a_pin0_conv: assert property (
    @(posedge CLK) disable iff (!RST_B)
    (code[0] == 3'h3) |=> PAD_DO[0] == $past(PERIPH_DO[FN_CONV_CLOCK]))
    else $error("pin 0 not driven by converter clock");

  a_pin0_miso: assert property (
    @(posedge CLK) disable iff (!RST_B)
    (code[0] == 3'h1) |=> PAD_DO[0] == $past(PERIPH_DO[FN_SPI1_MISO]))
    else $error("pin 0 not driven by spi1 miso");

  a_pin0_pwm: assert property (
    @(posedge CLK) disable iff (!RST_B)
    (code[0] == 3'h2) |=>
      PAD_DO[0] == $past(PERIPH_DO[FN_PWM_CHANNEL6_OUTPUT]))
    else $error("pin 0 not driven by pwm channel 6");

  a_pin1_valid: assert property (
    @(posedge CLK) disable iff (!RST_B)
    (code[1] == 3'h3) |=> PAD_DO[1] == $past(PERIPH_DO[FN_CONV_VALID]))
    else $error("pin 1 not driven by converter valid");

  a_pin1_debug: assert property (
    @(posedge CLK) disable iff (!RST_B)
    (code[1] == 3'h4) |=>
      PAD_DO[1] == $past(PERIPH_DO[FN_LINK_LAYER_DEBUG_BUS7]))
    else $error("pin 1 not driven by debug bit 7");

  a_pin2_clock: assert property (
    @(posedge CLK) disable iff (!RST_B)
    (code[2] == 3'h1) |=> PAD_DO[2] == $past(PERIPH_DO[FN_SPI1_CLK]))
    else $error("pin 2 not driven by spi1 clock");

  a_pin2_reserved: assert property (
    @(posedge CLK) disable iff (!RST_B)
    (code[2] == 3'h3 || code[2] == 3'h5 || code[2] == 3'h7) |=>
      PAD_OE[2] == $past(GPIO_OE[2]))
    else $error("reserved pin 2 code left gpio");

  a_pin3_cs: assert property (
    @(posedge CLK) disable iff (!RST_B)
    (code[3] == 3'h1) |=> PAD_DO[3] == $past(PERIPH_DO[FN_SPI1_CS]))
    else $error("pin 3 not driven by spi1 chip select");

  a_pin3_scl: assert property (
    @(posedge CLK) disable iff (!RST_B)
    (code[3] == 3'h6) |=> PAD_DO[3] == $past(PERIPH_DO[FN_I2C0_SCL]))
    else $error("pin 3 not driven by i2c0 scl");

  a_pin3_reserved: assert property (
    @(posedge CLK) disable iff (!RST_B)
    (code[3] == 3'h5 || code[3] == 3'h7) |=>
      PAD_OE[3] == $past(GPIO_OE[3]))
    else $error("reserved pin 3 code left gpio");

  a_pin5_mosi: assert property (
    @(posedge CLK) disable iff (!RST_B)
    (code[5] == 3'h1) |=> PAD_DO[5] == $past(PERIPH_DO[FN_SPI1_MOSI]))
    else $error("pin 5 not driven by spi1 mosi");

  a_pin5_sda: assert property (
    @(posedge CLK) disable iff (!RST_B)
    (code[5] == 3'h6) |=> PAD_DO[5] == $past(PERIPH_DO[FN_I2C0_SDA]))
    else $error("pin 5 not driven by i2c0 sda");

  a_unmapped_write: assert property (
    @(posedge CLK) disable iff (!RST_B)
    (WR && !sel_hit) |=> sel_r == $past(sel_r))
    else $error("write to unmapped address changed the register");

  a_low_reserved: assert property (
    @(posedge CLK) disable iff (!RST_B)
    (sel_r.low & ~LOW_MASK) == 8'h00)
    else $error("low select bit of a missing pin is set");

endmodule // port2_pin_function_select

// [testbench/testbench.sv]
module testbench
  import pinmux_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [ADDR_W-1:0] addr;
  logic [31:0] wdata, rdata, v;
  logic wr, rd;
  logic [NPIN-1:0] gpio_do, gpio_oe, gpio_di, pad_di, pad_do, pad_oe;
  logic [FN_COUNT-1:0] periph_do, periph_oe, periph_di;
  int mismatches, n_tests, cycles;
  // expected function index per pin and code {ext, second, low}
  int fn_tab [6][8] = '{
    '{0, 2, 12, 18, 0, 0, 0, 0},
    '{0, 1, 13, 17, 19, 0, 20, 0},
    '{0, 4, 9, 0, 16, 0, 5, 0},
    '{0, 3, 10, 14, 15, 0, 8, 0},
    '{0, 0, 0, 0, 0, 0, 0, 0},
    '{0, 1, 6, 11, 0, 0, 7, 0}};

  port2_pin_function_select i_port2_pin_function_select (
    .CLK(clk), .RST_B(rst_b), .ADDR(addr), .WDATA(wdata), .WR(wr),
    .RD(rd), .RDATA(rdata), .GPIO_DO(gpio_do), .GPIO_OE(gpio_oe),
    .GPIO_DI(gpio_di), .PERIPH_DO(periph_do), .PERIPH_OE(periph_oe),
    .PERIPH_DI(periph_di), .PAD_DI(pad_di), .PAD_DO(pad_do),
    .PAD_OE(pad_oe));

  always #5 clk = ~clk;

  // whole run needs well under a thousand cycles
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      mismatches++;
      summarize();
    end
  end

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic summarize();
    $display("tests %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask

  // write then read with no gap, as the bus allows
  task automatic wr_rd_reg(input logic [7:0] a, input logic [31:0] d,
                           output logic [31:0] q);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    q = rdata;
  endtask

  // drive only the expected source high so a misroute shows as 0
  task automatic pad_case(input int pin, input int code, input int fn);
    logic [FN_COUNT-1:0] oh;
    logic [31:0] sel;
    oh = '0;
    if (fn != 0)
      oh[fn] = 1'b1;
    sel = (32'((code >> 2) & 1) << (16 + pin))
        | (32'((code >> 1) & 1) << (8 + pin)) | (32'(code & 1) << pin);
    wr_reg(8'h08, sel);
    periph_do <= oh;
    periph_oe <= ~oh;
    gpio_do <= (fn == 0) ? 8'hff : 8'h00;
    gpio_oe <= (fn == 0) ? 8'h00 : 8'hff;
    repeat (2) @(posedge clk);
    #1;
    chk({31'h0, pad_do[pin]}, 32'h1);
    chk({31'h0, pad_oe[pin]}, 32'h0);
  endtask

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial
  begin
    addr = '0;
    wdata = '0;
    wr = 1'b0;
    rd = 1'b0;
    gpio_do = 8'ha5;
    gpio_oe = 8'h3c;
    periph_do = '1;
    periph_oe = '1;
    pad_di = '0;
    mismatches = 0;
    n_tests = 0;
    cycles = 0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    rd_reg(8'h08, v);
    chk(v, 32'h0);
    @(posedge clk);
    #1;
    chk(rdata, 32'h0);
    chk({24'h0, pad_do}, 32'ha5);
    chk({24'h0, pad_oe}, 32'h3c);
    $display("test reset done");
    wr_reg(8'h08, 32'hffff_ffff);
    rd_reg(8'h08, v);
    chk(v, 32'h00ff_ff2f);
    wr_reg(8'h0c, 32'h0);
    rd_reg(8'h08, v);
    chk(v, 32'h00ff_ff2f);
    rd_reg(8'h0c, v);
    chk(v, 32'h0);
    wr_reg(8'h08, 32'h0015_0a21);
    rd_reg(8'h08, v);
    chk(v, 32'h0015_0a21);
    wr_rd_reg(8'h08, 32'hffc3_5a9f, v);
    chk(v, 32'h00c3_5a0f);
    $display("test register done");
    for (int p = 0; p < 6; p++)
      for (int c = 0; c < 8; c++)
        pad_case(p, c, fn_tab[p][c]);
    $display("test routing done");
    wr_reg(8'h08, 32'h0000_2000);
    pad_di <= 8'h20;
    repeat (4) @(posedge clk);
    #1;
    chk({11'h0, periph_di}, 32'h40);
    chk({24'h0, gpio_di}, 32'h20);
    $display("test input done");
    summarize();
  end

endmodule // testbench
